// ---- rtl/tcic_defs.svh ----
// Constants for the timer counter with input capture.
// Assumes inclusion by bare name from the design files.
`ifndef TCIC_DEFS_SVH
`define TCIC_DEFS_SVH
`define TCIC_CNT_RESET 16'hFFFC
`define TCIC_CNT_MAX 16'hFFFF
`define TCIC_CLK_DIV2 2'h0
`define TCIC_CLK_DIV4 2'h1
`define TCIC_CLK_DIV8 2'h2
`define TCIC_CLK_EXT 2'h3
`define TCIC_PRE_MASK2 3'h1
`define TCIC_PRE_MASK4 3'h3
`define TCIC_PRE_MASK8 3'h7
`define TCIC_PRE_ZERO 3'h0
`define TCIC_SPACE_MIN 3'h4
`define TCIC_LO 7:0
`define TCIC_HI 15:8
`endif

// ---- rtl/tcic_pkg.sv ----
// Types for the timer counter with input capture.
// Assumes the constants header is included by users.
package tcic_pkg;
  typedef enum logic [1:0] {
    TCIC_RD_IDLE = 2'h1,
    TCIC_RD_HELD = 2'h2
  } tcic_rd_t;
endpackage

// ---- rtl/tcic_tick_if.sv ----
// Interface carrying the counter tick between internal modules.
// Assumes a single clock domain.
`timescale 1ns/1ps
interface tcic_tick_if;
  logic tick;
  modport src (output tick);
  modport snk (input tick);
endinterface

// ---- rtl/tcic_tick_gen.sv ----
// Tick generator: prescaler and external clock edge detector.
// Assumes ext pin already synchronous to clk; clk is the internal clock.
`timescale 1ns/1ps
`include "tcic_defs.svh"
module tcic_tick_gen (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt,
  input wire logic [1:0] clock_select,
  input wire logic ext_clock_edge_select,
  input wire logic ext_clock_pin,
  tcic_tick_if.src tk
);
  typedef struct packed {
    logic [2:0] pre;
    logic ext_d;
    logic [2:0] space;
    logic tick;
  } tcic_tg_t;
  tcic_tg_t s, next_s;
  logic [2:0] mask;
  logic edge_hit;

  // Prescaler mask picks the terminal count for divide by 2, 4 or 8
  always_comb begin
    case (clock_select)
      `TCIC_CLK_DIV2: mask = `TCIC_PRE_MASK2; // RULE_20
      `TCIC_CLK_DIV4: mask = `TCIC_PRE_MASK4;
      `TCIC_CLK_DIV8: mask = `TCIC_PRE_MASK8;
      default: mask = `TCIC_PRE_MASK8;
    endcase
  end

  // Active edge chosen by the edge select bit
  assign edge_hit = ext_clock_edge_select ? (ext_clock_pin & ~s.ext_d)
                                          : (~ext_clock_pin & s.ext_d); // RULE_11

  // Tick is a one-cycle pulse; halt freezes the prescaler and ticks, but the edge spacing countdown still runs
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    next_s.ext_d = ext_clock_pin;
    if (s.space != `TCIC_PRE_ZERO)
      next_s.space = s.space - 3'h1;
    if (!halt) begin // RULE_09
      if (clock_select == `TCIC_CLK_EXT) begin // RULE_10
        next_s.pre = `TCIC_PRE_ZERO;
        // Edges closer than the minimum spacing are dropped, not queued
        if (edge_hit && s.space == `TCIC_PRE_ZERO) begin // RULE_12
          next_s.tick = 1'b1;
          next_s.space = `TCIC_SPACE_MIN - 3'h1;
        end
      end else begin
        next_s.pre = (s.pre + 3'h1) & mask; // RULE_01
        if ((s.pre & mask) == mask)
          next_s.tick = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tk.tick = s.tick;
endmodule

// ---- rtl/tcic_capture.sv ----
// One input capture channel: edge detect, value, flag and read interlock.
// Assumes capture pin already synchronous to clk.
`timescale 1ns/1ps
`include "tcic_defs.svh"
module tcic_capture (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] count,
  input wire logic pin,
  input wire logic edge_rising,
  input wire logic rd_high,
  input wire logic acc_low,
  input wire logic status_acc,
  output logic [15:0] value,
  output logic flag
);
  typedef struct packed {
    logic pin_d;
    logic [15:0] value;
    logic flag;
    logic armed;
    logic blocked;
  } tcic_cap_t;
  tcic_cap_t s, next_s;
  logic hit;

  assign hit = edge_rising ? (pin & ~s.pin_d) : (~pin & s.pin_d); // RULE_14

  // Flag set wins over the two-step clear in the same cycle
  always_comb begin
    next_s = s;
    next_s.pin_d = pin;
    if (status_acc && s.flag)
      next_s.armed = 1'b1;
    if (acc_low) begin
      next_s.blocked = 1'b0;
      if (s.armed) begin
        next_s.flag = 1'b0; // RULE_17
        next_s.armed = 1'b0;
      end
    end
    if (rd_high)
      next_s.blocked = 1'b1; // RULE_18
    if (hit) begin
      next_s.flag = 1'b1; // RULE_15
      // The event still flags even while transfers are blocked
      if (!s.blocked)
        next_s.value = count; // RULE_13 RULE_19
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0; // RULE_21
    end else begin
      s <= next_s;
    end
  end

  assign value = s.value;
  assign flag = s.flag;
endmodule

// ---- rtl/tcic_timer.sv ----
// Top of the 16-bit free-running timer with overflow and two captures.
// Assumes a byte-wide register port with one-cycle read and write strobes.
// Operation
// RULE_01 - Counter divides internal clock by 2, 4, 8
// RULE_02 - Low byte write forces count to FFFC
// RULE_03 - Alternate pair reads count, keeps overflow flag
// RULE_04 - High read latches low byte until low read
// RULE_05 - Unlatched low read returns live count
// RULE_06 - Wrap to zero sets overflow flag
// RULE_07 - Overflow request needs both enables
// RULE_08 - Status read then low access clears overflow
// RULE_09 - Runs in wait, stops in halt
// RULE_10 - Select code three uses external clock pin
// RULE_11 - Edge select picks external clock transition
// RULE_12 - External edges need four-cycle spacing
// RULE_13 - Capture latches count on pin edge
// RULE_14 - Per-channel edge select bit
// RULE_15 - Capture sets channel flag
// RULE_16 - Capture request per common or own enable
// RULE_17 - Status access then low access clears capture
// RULE_18 - High read blocks capture until low read
// RULE_19 - Capture register holds most recent event
// RULE_20 - Select encoding 00,01,10 divide; 11 external
// RULE_21 - Reset clears flags, count to FFFC
`timescale 1ns/1ps
`include "tcic_defs.svh"
module tcic_timer (
  input wire logic clk,
  input wire logic rst,
  input wire logic halt,
  input wire logic [1:0] clock_select,
  input wire logic ext_clock_edge_select,
  input wire logic ext_clock_pin,
  input wire logic capture_input_one,
  input wire logic capture_input_two,
  input wire logic capture_edge_one,
  input wire logic capture_edge_two,
  input wire logic overflow_irq_enable,
  input wire logic capture_irq_common_enable,
  input wire logic capture_irq_enable_one,
  input wire logic capture_irq_enable_two,
  input wire logic timer_irq_global_enable,
  input wire logic rd_count_high_byte,
  input wire logic rd_count_low_byte,
  input wire logic wr_count_low_byte,
  input wire logic rd_alt_count_high_byte,
  input wire logic rd_alt_count_low_byte,
  input wire logic wr_alt_count_low_byte,
  input wire logic acc_flag_register,
  input wire logic rd_capture_high_byte_one,
  input wire logic acc_capture_low_byte_one,
  input wire logic rd_capture_high_byte_two,
  input wire logic acc_capture_low_byte_two,
  output logic [7:0] count_high_byte,
  output logic [7:0] count_low_byte,
  output logic [7:0] capture_high_byte_one,
  output logic [7:0] capture_low_byte_one,
  output logic [7:0] capture_high_byte_two,
  output logic [7:0] capture_low_byte_two,
  output logic overflow_flag,
  output logic capture_flag_one,
  output logic capture_flag_two,
  output logic timer_global_interrupt
);
  typedef struct packed {
    logic [15:0] count;
    tcic_pkg::tcic_rd_t rd;
    logic [7:0] low_buf;
    logic ovf;
    logic ovf_armed;
  } tcic_top_t;
  tcic_top_t s, next_s;
  tcic_tick_if tk();
  logic rd_high, rd_low, low_live;
  logic [7:0] low_out;
  logic cap_flag_one, cap_flag_two;
  logic [15:0] cap_val_one, cap_val_two;
  logic irq_ovf, irq_cap_one, irq_cap_two;

  tcic_tick_gen u_tick (
    .clk(clk),
    .rst(rst),
    .halt(halt),
    .clock_select(clock_select),
    .ext_clock_edge_select(ext_clock_edge_select),
    .ext_clock_pin(ext_clock_pin),
    .tk(tk)
  );

  tcic_capture u_cap_one (
    .clk(clk),
    .rst(rst),
    .count(s.count),
    .pin(capture_input_one),
    .edge_rising(capture_edge_one),
    .rd_high(rd_capture_high_byte_one),
    .acc_low(acc_capture_low_byte_one),
    .status_acc(acc_flag_register),
    .value(cap_val_one),
    .flag(cap_flag_one)
  );

  tcic_capture u_cap_two (
    .clk(clk),
    .rst(rst),
    .count(s.count),
    .pin(capture_input_two),
    .edge_rising(capture_edge_two),
    .rd_high(rd_capture_high_byte_two),
    .acc_low(acc_capture_low_byte_two),
    .status_acc(acc_flag_register),
    .value(cap_val_two),
    .flag(cap_flag_two)
  );

  // Both pairs share one latch so either pair completes the sequence
  assign rd_high = rd_count_high_byte | rd_alt_count_high_byte; // RULE_03
  assign rd_low = rd_count_low_byte | rd_alt_count_low_byte;
  assign low_live = (s.rd != tcic_pkg::TCIC_RD_HELD);

  // Low byte data: buffered while a sequence is open, else live
  assign low_out = low_live ? s.count[`TCIC_LO] : s.low_buf; // RULE_05

  // Main state update
  always_comb begin
    next_s = s;
    case (s.rd)
      tcic_pkg::TCIC_RD_IDLE: begin
        if (rd_high) begin
          next_s.rd = tcic_pkg::TCIC_RD_HELD; // RULE_04
          next_s.low_buf = s.count[`TCIC_LO];
        end
      end
      tcic_pkg::TCIC_RD_HELD: begin
        // Repeated high reads keep the first buffered low byte
        if (rd_low)
          next_s.rd = tcic_pkg::TCIC_RD_IDLE; // RULE_04
      end
      default: next_s.rd = tcic_pkg::TCIC_RD_IDLE;
    endcase
    if (acc_flag_register && s.ovf)
      next_s.ovf_armed = 1'b1;
    // Only the main low byte clears overflow; the alternate pair never does
    if ((rd_count_low_byte || wr_count_low_byte) && s.ovf_armed) begin
      next_s.ovf = 1'b0; // RULE_08 RULE_03
      next_s.ovf_armed = 1'b0;
    end
    if (wr_count_low_byte || wr_alt_count_low_byte) begin
      next_s.count = `TCIC_CNT_RESET; // RULE_02
    end else if (tk.tick) begin
      next_s.count = s.count + 16'h0001; // RULE_01
      // Set wins over a clear landing in the same cycle
      if (s.count == `TCIC_CNT_MAX)
        next_s.ovf = 1'b1; // RULE_06
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s.count <= `TCIC_CNT_RESET; // RULE_21 RULE_09
      s.rd <= tcic_pkg::TCIC_RD_IDLE;
      s.low_buf <= 8'h00;
      s.ovf <= 1'b0;
      s.ovf_armed <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  // Pending flags only reach the request line while enabled
  assign irq_ovf = s.ovf & overflow_irq_enable & timer_irq_global_enable; // RULE_07
  assign irq_cap_one = cap_flag_one & timer_irq_global_enable &
                       (capture_irq_common_enable | capture_irq_enable_one); // RULE_16
  assign irq_cap_two = cap_flag_two & timer_irq_global_enable &
                       (capture_irq_common_enable | capture_irq_enable_two); // RULE_16
  assign timer_global_interrupt = irq_ovf | irq_cap_one | irq_cap_two;

  // Read data comes straight from state registers
  assign count_high_byte = s.count[`TCIC_HI];
  assign count_low_byte = low_out;
  assign capture_high_byte_one = cap_val_one[`TCIC_HI];
  assign capture_low_byte_one = cap_val_one[`TCIC_LO];
  assign capture_high_byte_two = cap_val_two[`TCIC_HI];
  assign capture_low_byte_two = cap_val_two[`TCIC_LO];
  assign overflow_flag = s.ovf;
  assign capture_flag_one = cap_flag_one;
  assign capture_flag_two = cap_flag_two;
endmodule

// ---- verif/tcic_pin_model.sv ----
// Far-side model: the two capture pins and the external clock pin.
// Assumes calls land just after a rising clk edge.
`timescale 1ns/1ps
module tcic_pin_model (
  input wire logic clk,
  output logic capture_input_one,
  output logic capture_input_two,
  output logic ext_clock_pin
);
  // Pins idle low until commanded
  initial begin
    capture_input_one = 1'b0;
    capture_input_two = 1'b0;
    ext_clock_pin = 1'b0;
  end
  // Toggle one capture pin; the level then holds until the next call
  task automatic cap_flip(input int ch);
    if (ch == 1) capture_input_one = ~capture_input_one;
    else capture_input_two = ~capture_input_two;
  endtask
  // Each toggle holds five clocks, so edges never fall inside the four-cycle minimum spacing
  task automatic ext_edges(input int n);
    repeat (n) begin
      ext_clock_pin = ~ext_clock_pin;
      repeat (5) @(posedge clk);
      #1;
    end
  endtask
endmodule

// ---- verif/tcic_timer_checker.sv ----
// Concurrent checks on the timer top ports.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tcic_timer_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_count_low_byte,
  input wire logic wr_alt_count_low_byte,
  input wire logic rd_count_low_byte,
  input wire logic rd_alt_count_low_byte,
  input wire logic acc_flag_register,
  input wire logic capture_input_one,
  input wire logic capture_edge_one,
  input wire logic rd_capture_high_byte_one,
  input wire logic acc_capture_low_byte_one,
  input wire logic overflow_irq_enable,
  input wire logic timer_irq_global_enable,
  input wire logic capture_irq_enable_two,
  input wire logic [7:0] count_high_byte,
  input wire logic [7:0] capture_high_byte_one,
  input wire logic [7:0] capture_low_byte_one,
  input wire logic overflow_flag,
  input wire logic capture_flag_one,
  input wire logic capture_flag_two,
  input wire logic timer_global_interrupt
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  // Reload and overflow behaviour
  a_write_reload: assert property (
    (wr_count_low_byte || wr_alt_count_low_byte) |=> count_high_byte == 8'hFF) else $error("reload missed");
  a_wrap_sets_flag: assert property (
    (count_high_byte == 8'h00 && $past(count_high_byte) == 8'hFF) |-> overflow_flag) else $error("wrap no flag");
  a_alt_keeps_flag: assert property (
    (overflow_flag && rd_alt_count_low_byte && !rd_count_low_byte && !wr_count_low_byte) |=> overflow_flag)
    else $error("alt read cleared flag");
  a_ovf_clear_seq: assert property (
    (acc_flag_register && overflow_flag) ##1 (rd_count_low_byte && count_high_byte != 8'hFF) |=> !overflow_flag)
    else $error("flag not cleared");
  a_ovf_irq_out: assert property (
    (overflow_flag && overflow_irq_enable && timer_irq_global_enable) |-> timer_global_interrupt)
    else $error("overflow irq missing");
  // Capture channel behaviour
  a_capture_sets_flag: assert property (
    ($rose(capture_input_one) && capture_edge_one || $fell(capture_input_one) && !capture_edge_one)
    |=> capture_flag_one) else $error("capture flag missing");
  a_capture_held: assert property (
    (rd_capture_high_byte_one ##1 !acc_capture_low_byte_one)
    |=> $stable({capture_high_byte_one, capture_low_byte_one})) else $error("frozen value moved");
  a_capture_own_irq: assert property (
    (capture_flag_two && capture_irq_enable_two && timer_irq_global_enable) |-> timer_global_interrupt)
    else $error("capture irq missing");
  c_ovf_irq: cover property (overflow_flag && timer_global_interrupt);
  c_capture: cover property ($rose(capture_flag_one));
  c_clear: cover property ($fell(overflow_flag));
endmodule
bind tcic_timer tcic_timer_checker tcic_timer_checker_i (.*);

// ---- verif/tcic_timer_tb_top.sv ----
// Self-checking bench for the timer with input capture.
// Assumes the pin model drives the capture and external clock pins.
`timescale 1ns/1ps
module tcic_timer_tb_top;
  logic clk, rst, halt, ext_clock_edge_select, capture_edge_one, capture_edge_two;
  logic overflow_irq_enable, capture_irq_common_enable, capture_irq_enable_one;
  logic capture_irq_enable_two, timer_irq_global_enable, overflow_flag;
  logic capture_flag_one, capture_flag_two, timer_global_interrupt;
  logic [1:0] clock_select;
  logic [10:0] stb;
  logic [7:0] count_high_byte, count_low_byte, capture_high_byte_one;
  logic [7:0] capture_low_byte_one, capture_high_byte_two, capture_low_byte_two;
  wire capture_input_one, capture_input_two, ext_clock_pin;
  int error_cnt = 0;
  int comparisons = 0;
  // Access strobes share one vector so one task drives them all
  wire rd_count_high_byte = stb[0];
  wire rd_count_low_byte = stb[1];
  wire wr_count_low_byte = stb[2];
  wire rd_alt_count_high_byte = stb[3];
  wire rd_alt_count_low_byte = stb[4];
  wire wr_alt_count_low_byte = stb[5];
  wire acc_flag_register = stb[6];
  wire rd_capture_high_byte_one = stb[7];
  wire acc_capture_low_byte_one = stb[8];
  wire rd_capture_high_byte_two = stb[9];
  wire acc_capture_low_byte_two = stb[10];
  wire [15:0] cnt = {count_high_byte, count_low_byte};
  tcic_timer tcic_timer_i (.*);
  tcic_pin_model tcic_pin_model_i (.*);
  // Clock source
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task chk(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One strobe for exactly one sampling edge
  task pulse(input int k);
    stb[k] = 1'b1;
    step(1);
    stb[k] = 1'b0;
  endtask
  task complete_run();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Buffered low byte survives a repeated high read
  task t_latch();
    logic [7:0] lo;
    lo = count_low_byte;
    pulse(0);
    step(5);
    pulse(0);
    pulse(3);
    stb[1] = 1'b1;
    chk(count_low_byte, lo);
    step(1);
    stb[1] = 1'b0;
    // Alternate pair opens and closes its own sequence
    lo = count_low_byte;
    pulse(3);
    step(4);
    stb[4] = 1'b1;
    chk(count_low_byte, lo);
    step(1);
    stb[4] = 1'b0;
  endtask
  // Eight periods of each divider give exactly eight counts
  task t_prescale();
    logic [7:0] a;
    for (int s = 0; s < 3; s++) begin
      clock_select = s[1:0];
      step(3);
      a = count_low_byte;
      step(8 << (s + 1));
      chk(8'(count_low_byte - a), 8'h08);
    end
  endtask
  // Five toggles give three edges of the selected kind, two of the other
  task t_ext();
    logic [7:0] a;
    clock_select = 2'h3;
    for (int e = 1; e >= 0; e--) begin
      ext_clock_edge_select = e[0];
      step(6);
      a = count_low_byte;
      tcic_pin_model_i.ext_edges(5);
      step(6);
      chk(8'(count_low_byte - a), 8'h03);
    end
  endtask
  task t_overflow();
    clock_select = 2'h0;
    // Flag is already set from the one earlier wrap; clear it so the next wrap is seen
    pulse(6);
    pulse(2);
    chk(cnt, 16'hFFFC);
    chk(overflow_flag, 1'b0);
    step(10);
    chk({overflow_flag, timer_global_interrupt}, 2'h2);
    overflow_irq_enable = 1'b1;
    step(1);
    chk(timer_global_interrupt, 1'b0);
    timer_irq_global_enable = 1'b1;
    step(1);
    chk(timer_global_interrupt, 1'b1);
    pulse(6);
    pulse(4);
    chk(overflow_flag, 1'b1);
    pulse(6);
    pulse(1);
    chk({overflow_flag, timer_global_interrupt}, 2'h0);
    pulse(5);
    chk(cnt, 16'hFFFC);
    overflow_irq_enable = 1'b0;
  endtask
  task t_capture();
    logic [15:0] v;
    clock_select = 2'h2;
    capture_edge_one = 1'b1;
    step(2);
    v = cnt;
    tcic_pin_model_i.cap_flip(1);
    step(1);
    chk({capture_flag_one, capture_high_byte_one, capture_low_byte_one}, {1'b1, v});
    pulse(7);
    tcic_pin_model_i.cap_flip(1);
    step(20);
    tcic_pin_model_i.cap_flip(1);
    step(2);
    chk({capture_high_byte_one, capture_low_byte_one}, v);
    pulse(8);
    tcic_pin_model_i.cap_flip(1);
    step(1);
    v = cnt;
    tcic_pin_model_i.cap_flip(1);
    step(1);
    chk({capture_high_byte_one, capture_low_byte_one}, v);
    pulse(6);
    pulse(8);
    chk(capture_flag_one, 1'b0);
    tcic_pin_model_i.cap_flip(2);
    step(3);
    chk(capture_flag_two, 1'b0);
    v = cnt;
    tcic_pin_model_i.cap_flip(2);
    step(1);
    chk({timer_global_interrupt, capture_high_byte_two, capture_low_byte_two}, {1'b0, v});
    capture_irq_enable_two = 1'b1;
    step(1);
    chk(timer_global_interrupt, 1'b1);
    capture_irq_enable_two = 1'b0;
    capture_irq_common_enable = 1'b1;
    step(1);
    chk(timer_global_interrupt, 1'b1);
  endtask
  // Channel one own enable, channel two rising edge and its read interlock
  task t_cap_more();
    logic [15:0] v;
    capture_irq_common_enable = 1'b0;
    capture_edge_one = 1'b0;
    step(1);
    chk(timer_global_interrupt, 1'b0);
    v = cnt;
    tcic_pin_model_i.cap_flip(1);
    step(1);
    chk({capture_flag_one, capture_high_byte_one, capture_low_byte_one}, {1'b1, v});
    chk(timer_global_interrupt, 1'b0);
    capture_irq_enable_one = 1'b1;
    step(1);
    chk(timer_global_interrupt, 1'b1);
    // Let the count move on so a leaked transfer would show
    step(8);
    capture_edge_two = 1'b1;
    v = {capture_high_byte_two, capture_low_byte_two};
    pulse(9);
    tcic_pin_model_i.cap_flip(2);
    step(2);
    chk({capture_high_byte_two, capture_low_byte_two}, v);
    pulse(10);
    tcic_pin_model_i.cap_flip(2);
    step(1);
    v = cnt;
    tcic_pin_model_i.cap_flip(2);
    step(1);
    chk({capture_flag_two, capture_high_byte_two, capture_low_byte_two}, {1'b1, v});
    pulse(6);
    pulse(10);
    chk(capture_flag_two, 1'b0);
  endtask
  // Halt freezes the count, release lets it run on
  task t_halt();
    logic [15:0] v;
    halt = 1'b1;
    step(1);
    v = cnt;
    step(20);
    chk(cnt, v);
    halt = 1'b0;
    step(20);
    chk(cnt == v, 1'b0);
  endtask
  // Main sequence
  initial begin
    {halt, stb, clock_select, ext_clock_edge_select, capture_edge_one, capture_edge_two} = '0;
    {overflow_irq_enable, capture_irq_common_enable, capture_irq_enable_one} = '0;
    {capture_irq_enable_two, timer_irq_global_enable} = '0;
    rst = 1'b1;
    step(16);
    chk(cnt, 16'hFFFC);
    chk({overflow_flag, capture_flag_one, capture_flag_two, capture_high_byte_one, capture_low_byte_two}, '0);
    rst = 1'b0;
    t_latch();
    t_prescale();
    t_ext();
    t_overflow();
    t_capture();
    t_cap_more();
    t_halt();
    complete_run();
  end
  // Watchdog far beyond the few hundred cycles the scenarios need
  initial begin
    #200000;
    error_cnt++;
    complete_run();
  end
endmodule
